/* File: rtl/tft_source_sampling_shifter.sv */
// Sampling-timing shifter and dual hold banks of a 480-column TFT source driver
// Functional notes
// [RULE_01] Active cascade input high at a rising shift-clock edge starts a sampling line.
// [RULE_02] Direction high: right cascade pin is input, left cascade pin is output.
// [RULE_03] Direction low: left cascade pin is input, right cascade pin is output.
// [RULE_04] Right shift walks columns 1 to 480; left shift walks 480 to 1.
// [RULE_05] Each strobe fires on a rising edge of its group's shift clock.
// [RULE_06] Sequential: clock one strobes 3n-2 right or 3n left; two strobes 3n-1.
// [RULE_07] Sequential: clock three strobes the triplet's remaining column.
// [RULE_08] Simultaneous: clock one strobes whole triplet; controller ties clocks two, three.
// [RULE_09] Mode high selects simultaneous, low or open selects sequential.
// [RULE_10] Bank select high: bank one samples, bank two drives; low is reverse.
// [RULE_11] Video input 1 feeds 3n-2, input 2 feeds 3n-1, input 3 feeds 3n.
// [RULE_12] Controller keeps the test input low during operation.
// [RULE_13] Controller changes bank select only during vertical blanking.
// [RULE_14] A stretched start pulse still gives one normal first strobe.
// [RULE_15] After the last stage a start pulse goes out on the cascade output.
`timescale 1ns/10ps
`default_nettype none

module tft_source_sampling_shifter (
  input  wire logic                          clk,                 // 50 MHz system clock
  input  wire logic                          rst_n,               // Async reset, active low
  input  wire logic                          right_cascade_start, // Right cascade pin, input side
  input  wire logic                          left_cascade_start,  // Left cascade pin, input side
  output var  tft_sampling_pkg::casc_pin_s   right_cascade_out,   // Right cascade pin drive/enable
  output var  tft_sampling_pkg::casc_pin_s   left_cascade_out,    // Left cascade pin drive/enable
  input  wire logic                          shift_clock_one,     // Shift clock 1 pin
  input  wire logic                          shift_clock_two,     // Shift clock 2 pin
  input  wire logic                          shift_clock_three,   // Shift clock 3 pin
  input  wire logic                          shift_direction,     // High right shift, low left
  input  wire logic                          sampling_mode,       // High simultaneous, low sequential
  input  wire logic                          hold_bank_select,    // Hold bank selector
  input  wire logic                          test_mode,           // Factory test, keep low
  input  wire tft_sampling_pkg::video_t      colour_video_inputs, // Three colour video samples
  output logic [tft_sampling_pkg::COLS-1:0]  sampling_strobe,     // One-cycle column strobes
  output tft_sampling_pkg::column_t          column_outputs,      // Held values per column
  output logic                               sequencer_busy       // High while a line is sampled
);
  import tft_sampling_pkg::*;

  // Pin synchroniser: change counts when stages two and three agree
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s1_r;
  logic [PIN_W-1:0] pin_s2_r;
  logic [PIN_W-1:0] pin_s3_r;
  logic [PIN_W-1:0] pin_lvl_r;
  logic [PIN_W-1:0] pin_agree;
  logic [PIN_W-1:0] pin_lvl_nxt;
  logic [PIN_W-1:0] pin_rise;

  assign pin_raw = {test_mode, hold_bank_select, sampling_mode, shift_direction,
                    left_cascade_start, right_cascade_start,
                    shift_clock_three, shift_clock_two, shift_clock_one};
  assign pin_agree   = ~(pin_s2_r ^ pin_s3_r);
  assign pin_lvl_nxt = (pin_agree & pin_s2_r) | (~pin_agree & pin_lvl_r);
  assign pin_rise    = pin_lvl_nxt & ~pin_lvl_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r  <= PIN_RESET;
      pin_s2_r  <= PIN_RESET;
      pin_s3_r  <= PIN_RESET;
      pin_lvl_r <= PIN_RESET;
    end else begin
      pin_s1_r  <= pin_raw;
      pin_s2_r  <= pin_s1_r;
      pin_s3_r  <= pin_s2_r;
      pin_lvl_r <= pin_lvl_nxt;
    end
  end

  // Video passes the same depth so it lines up with the clock edges
  video_t vid_s1_r;
  video_t vid_s2_r;
  video_t vid_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vid_s1_r <= '0;
      vid_s2_r <= '0;
      vid_r    <= '0;
    end else begin
      vid_s1_r <= colour_video_inputs;
      vid_s2_r <= vid_s1_r;
      vid_r    <= vid_s2_r;
    end
  end

  // Decoded pin levels and edges
  wire       dir_lvl   = pin_lvl_r[PIN_DIR];
  wire       sim_lvl   = pin_lvl_r[PIN_MODE];  // [RULE_09]
  wire       bank_lvl  = pin_lvl_r[PIN_BANK];
  wire       test_lvl  = pin_lvl_r[PIN_TEST];
  wire [2:0] clk_rise  = pin_rise[PIN_CLK_THR:PIN_CLK_ONE];
  wire       start_lvl = dir_lvl ? pin_lvl_r[PIN_RSTART] : pin_lvl_r[PIN_LSTART]; // [RULE_02] [RULE_03]

  // Sequencer state
  seq_state_e state_r;
  seq_state_e state_nxt;
  line_cfg_s  cfg_r;
  logic [7:0] trip_r;
  logic [7:0] trip_nxt;
  logic [1:0] phase_r;
  logic [1:0] phase_nxt;
  logic       arm_r;
  logic       casc_r;
  logic       casc_nxt;
  logic [COLS-1:0] strobe_r;

  // Start is taken once per pulse; arm re-opens only after start is seen low
  wire accept = (state_r == ST_IDLE) && clk_rise[0] && start_lvl && arm_r && !test_lvl; // [RULE_01] [RULE_14] [RULE_12]

  // Configuration is frozen for the whole line at acceptance
  line_cfg_s cur_cfg;
  assign cur_cfg = accept ? line_cfg_s'{right_shift: dir_lvl, simultaneous: sim_lvl} : cfg_r;

  wire [7:0] pos_trip  = accept ? (dir_lvl ? TRIP_FIRST : TRIP_MAX) : trip_r;    // [RULE_04]
  wire [1:0] pos_phase = accept ? PHASE_A : phase_r;
  wire       step      = (state_r == ST_RUN) &&
                         (cfg_r.simultaneous ? clk_rise[0] : clk_rise[phase_r]); // [RULE_05]
  wire       fire      = accept || step;

  // Column position of the strobe
  wire [8:0] base     = {1'b0, pos_trip} + {pos_trip, 1'b0};
  wire [1:0] col_off  = cur_cfg.right_shift ? pos_phase : (PHASE_C - pos_phase); // [RULE_06] [RULE_07]
  wire [8:0] col_idx  = base + {7'h00, col_off};
  wire       trip_end = cur_cfg.simultaneous || (pos_phase == PHASE_C);
  wire       last_pos = trip_end && (pos_trip == (cur_cfg.right_shift ? TRIP_MAX : TRIP_FIRST));

  wire [COLS-1:0] strobe_pat = cur_cfg.simultaneous ? (STROBE_TRIO << base)      // [RULE_08]
                                                    : (STROBE_ONE << col_idx);   // [RULE_06]
  wire [COLS-1:0] strobe_nxt = fire ? strobe_pat : STROBE_NONE;

  always_comb begin
    state_nxt = state_r;
    trip_nxt  = trip_r;
    phase_nxt = phase_r;
    casc_nxt  = casc_r;
    if (test_lvl) begin
      state_nxt = ST_IDLE;
      casc_nxt  = 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (accept) begin
            state_nxt = ST_RUN;
          end
        end
        ST_RUN: begin
          if (step && last_pos) begin
            state_nxt = ST_CASC;
            casc_nxt  = 1'b1;                       // [RULE_15]
          end
        end
        ST_CASC: begin
          if (clk_rise[0]) begin
            state_nxt = ST_IDLE;
            casc_nxt  = 1'b0;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
          casc_nxt  = 1'b0;
        end
      endcase
      if (fire && !last_pos) begin
        if (trip_end) begin
          phase_nxt = PHASE_A;
          trip_nxt  = cur_cfg.right_shift ? (pos_trip + TRIP_STEP)
                                          : (pos_trip - TRIP_STEP); // [RULE_04]
        end else begin
          phase_nxt = pos_phase + 2'h1;
        end
      end
      if (accept && last_pos) begin
        state_nxt = ST_CASC;
        casc_nxt  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r  <= ST_IDLE;
      cfg_r    <= '0;
      trip_r   <= TRIP_FIRST;
      phase_r  <= PHASE_A;
      arm_r    <= 1'b0;
      casc_r   <= 1'b0;
      strobe_r <= STROBE_NONE;
    end else begin
      state_r  <= state_nxt;
      cfg_r    <= cur_cfg;
      trip_r   <= trip_nxt;
      phase_r  <= phase_nxt;
      arm_r    <= accept ? 1'b0 : (arm_r || !start_lvl);      // [RULE_14]
      casc_r   <= casc_nxt;
      strobe_r <= strobe_nxt;
    end
  end

  assign sampling_strobe = strobe_r;
  assign sequencer_busy  = (state_r != ST_IDLE);

  // Cascade pins: the pin that is not the start input is driven
  assign left_cascade_out  = '{drive: casc_r && dir_lvl,  enable: dir_lvl};  // [RULE_02]
  assign right_cascade_out = '{drive: casc_r && !dir_lvl, enable: !dir_lvl}; // [RULE_03]

  // Hold banks: one samples while the other feeds the column outputs
  sample_t hold_bank_one_r [COLS];
  sample_t hold_bank_two_r [COLS];
  sample_t column_r        [COLS];

  for (genvar c = 0; c < COLS; c++) begin : g_col
    localparam int CH = c % VIDEO_CH;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        hold_bank_one_r[c] <= '0;
        hold_bank_two_r[c] <= '0;
        column_r[c]        <= '0;
      end else begin
        if (strobe_nxt[c] && bank_lvl) begin
          hold_bank_one_r[c] <= vid_r[CH];                   // [RULE_10] [RULE_11]
        end
        if (strobe_nxt[c] && !bank_lvl) begin
          hold_bank_two_r[c] <= vid_r[CH];                   // [RULE_10] [RULE_11]
        end
        column_r[c] <= bank_lvl ? hold_bank_two_r[c] : hold_bank_one_r[c]; // [RULE_10]
      end
    end
    assign column_outputs[c] = column_r[c];
  end

  // Middle column of the current triplet: clock two owns it in either direction
  wire [8:0] mid_col = {1'b0, trip_r} + {trip_r, 1'b0} + 9'h001;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  start_take_a: assert property (accept |=> (state_r != ST_IDLE) && (strobe_r != STROBE_NONE)) // [RULE_01]
    else $error("start pulse not taken");
  right_pins_a: assert property (dir_lvl |-> left_cascade_out.enable && !right_cascade_out.enable) // [RULE_02]
    else $error("right shift pin roles wrong");
  left_pins_a: assert property (!dir_lvl |-> right_cascade_out.enable && !left_cascade_out.enable) // [RULE_03]
    else $error("left shift pin roles wrong");
  first_column_a: assert property (accept && dir_lvl && !sim_lvl |=> strobe_r[0]) // [RULE_04]
    else $error("right shift did not start at column one");
  last_column_a: assert property (accept && !dir_lvl && !sim_lvl |=> strobe_r[COLS-1]) // [RULE_04]
    else $error("left shift did not start at column 480");
  strobe_edge_a: assert property ((strobe_r != STROBE_NONE) |-> $past(clk_rise != 3'h0)) // [RULE_05]
    else $error("strobe without a shift-clock edge");
  seq_single_a: assert property (step && !cfg_r.simultaneous |=> $onehot(strobe_r)) // [RULE_06] [RULE_07]
    else $error("sequential strobe not one column");
  seq_middle_a: assert property (step && !cfg_r.simultaneous && phase_r == PHASE_B
                                 |-> clk_rise[1] ##1 strobe_r[mid_col]) // [RULE_06]
    else $error("clock two strobe misplaced");
  sim_trio_a: assert property (step && cfg_r.simultaneous |=> $countones(strobe_r) == 3) // [RULE_08]
    else $error("simultaneous strobe not three columns");
  bank_route_a: assert property (strobe_nxt[1] && bank_lvl |=> hold_bank_one_r[1] == $past(vid_r[1])) // [RULE_10] [RULE_11]
    else $error("video two not held in bank one");
  bank_keep_a: assert property (strobe_nxt[2] && !bank_lvl |=> hold_bank_one_r[2] == $past(hold_bank_one_r[2])) // [RULE_10]
    else $error("output bank overwritten");
  no_restart_a: assert property ((state_r != ST_IDLE) |-> !accept) // [RULE_14]
    else $error("stretched start retriggered");
  casc_out_a: assert property (step && last_pos && !test_lvl |=> casc_r ##1 (casc_r || state_r == ST_IDLE)) // [RULE_15]
    else $error("cascade start not issued");

  right_seq_c: cover property (accept && dir_lvl && !sim_lvl);
  left_seq_c:  cover property (accept && !dir_lvl && !sim_lvl);
  sim_line_c:  cover property (accept && sim_lvl);
  casc_c:      cover property ($rose(casc_r));

endmodule // tft_source_sampling_shifter

`default_nettype wire

/* File: rtl/tft_sampling_pkg.sv */
// Shared constants and types for the TFT column-driver sampling shifter
package tft_sampling_pkg;

  // Panel geometry
  localparam int COLS     = 480;
  localparam int TRIPLETS = 160;
  localparam int VIDEO_CH = 3;
  localparam int VIDEO_W  = 8;

  // Bit positions in the synchronised pin vector
  localparam int PIN_W       = 9;
  localparam int PIN_CLK_ONE = 0;
  localparam int PIN_CLK_TWO = 1;
  localparam int PIN_CLK_THR = 2;
  localparam int PIN_RSTART  = 3;
  localparam int PIN_LSTART  = 4;
  localparam int PIN_DIR     = 5;
  localparam int PIN_MODE    = 6;
  localparam int PIN_BANK    = 7;
  localparam int PIN_TEST    = 8;
  localparam logic [PIN_W-1:0] PIN_RESET = 9'h000;

  // Triplet index and phase within a triplet
  localparam logic [7:0] TRIP_FIRST = 8'h00;
  localparam logic [7:0] TRIP_MAX   = 8'h9F;
  localparam logic [7:0] TRIP_STEP  = 8'h01;
  localparam logic [1:0] PHASE_A    = 2'h0;
  localparam logic [1:0] PHASE_B    = 2'h1;
  localparam logic [1:0] PHASE_C    = 2'h2;

  // Strobe patterns before shifting to the column position
  localparam logic [COLS-1:0] STROBE_NONE = {COLS{1'b0}};
  localparam logic [COLS-1:0] STROBE_ONE  = {{(COLS-1){1'b0}}, 1'b1};
  localparam logic [COLS-1:0] STROBE_TRIO = {{(COLS-3){1'b0}}, 3'h7};

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_CASC = 3'b100
  } seq_state_e;

  typedef struct packed {
    logic drive;
    logic enable;
  } casc_pin_s;

  typedef struct packed {
    logic right_shift;
    logic simultaneous;
  } line_cfg_s;

  typedef logic [VIDEO_W-1:0]                sample_t;
  typedef logic [VIDEO_CH-1:0][VIDEO_W-1:0]  video_t;
  typedef logic [COLS-1:0][VIDEO_W-1:0]      column_t;

endpackage

/* File: tb/panel_ctrl_model.sv */
// Panel timing controller model: shift clocks, start pulse and video for one line
`timescale 1ns/10ps
`default_nettype none

module panel_ctrl_model (
  input  wire logic                 clk,     // Bench clock
  input  wire logic                 run,     // High one cycle to send a line
  input  wire logic                 mode,    // High for one-phase clocking
  input  wire logic                 stretch, // Keep start high into later clocks
  output logic [2:0]                sclk,    // Shift clocks one to three
  output logic                      start,   // Start pulse for the active cascade pin
  output logic                      test,    // Test pin level
  output var tft_sampling_pkg::video_t video, // Video samples
  output logic                      done     // High while idle
);
  import tft_sampling_pkg::*;
  int idx;
  int last;
  assign test = 1'b0;
  initial begin
    sclk  = 3'h0;
    start = 1'b0;
    video = '0;
    done  = 1'b1;
    forever begin
      @(posedge clk iff run);
      @(negedge clk);
      done = 1'b0;
      last = mode ? TRIPLETS : COLS;
      // One extra clock one after the last strobe ends the cascade pulse
      for (int k = 0; k <= last; k++) begin
        idx = mode ? 0 : k % 3;
        for (int j = 0; j < VIDEO_CH; j++) begin
          video[j] = sample_t'(k * 3 + j + 1);
        end
        // Start is set up while the clocks are low, ahead of the rise that reads it
        start = (k == 0) || (stretch && k <= 3);
        repeat (4) @(negedge clk);
        sclk[idx] = 1'b1;
        repeat (6) @(negedge clk);
        sclk[idx] = 1'b0;
      end
      start = 1'b0;
      done  = 1'b1;
    end
  end
endmodule // panel_ctrl_model

`default_nettype wire

/* File: tb/tft_source_sampling_shifter_test.sv */
// Self-checking bench for the TFT sampling shifter
`timescale 1ns/10ps
`default_nettype none

module tft_source_sampling_shifter_test;
  import tft_sampling_pkg::*;
  typedef struct packed {
    logic       dir;
    logic       mode;
    logic       bank;
    logic [9:0] count;
    logic [1:0] casc;
  } row_s;
  logic            clk         = 1'b0;
  logic            rst_n       = 1'b0;
  logic            dir         = 1'b1;
  logic            mode        = 1'b0;
  logic            bank        = 1'b0;
  logic            run         = 1'b0;
  logic            stretch     = 1'b0;
  logic [2:0]      sclk;
  logic            pstart;
  logic            test;
  logic            done;
  logic            busy;
  video_t          video;
  casc_pin_s       rout;
  casc_pin_s       lout;
  logic [COLS-1:0] strobe;
  logic [COLS-1:0] es;
  column_t         cols;
  sample_t         exp_one [COLS] = '{default: 8'h00};
  sample_t         exp_two [COLS] = '{default: 8'h00};
  int              nstb;
  logic [1:0]      seen;
  int              num_errors  = 0;
  int              check_count = 0;
  row_s            rows [4] = '{'{1'b1, 1'b0, 1'b1, 10'd480, 2'b01},
                                '{1'b0, 1'b0, 1'b0, 10'd480, 2'b10},
                                '{1'b1, 1'b1, 1'b0, 10'd160, 2'b01},
                                '{1'b0, 1'b1, 1'b1, 10'd160, 2'b10}};
  wire logic right_pin = rout.enable ? rout.drive : (dir ? pstart : ~rout.drive);
  wire logic left_pin  = lout.enable ? lout.drive : (!dir ? pstart : ~lout.drive);

  initial forever #10 clk = ~clk;

  panel_ctrl_model panel_ctrl_model_inst (
    .clk(clk), .run(run), .mode(mode), .stretch(stretch), .sclk(sclk),
    .start(pstart), .test(test), .video(video), .done(done));

  tft_source_sampling_shifter tft_source_sampling_shifter_inst (
    .clk(clk), .rst_n(rst_n), .right_cascade_start(right_pin), .left_cascade_start(left_pin),
    .right_cascade_out(rout), .left_cascade_out(lout), .shift_clock_one(sclk[0]),
    .shift_clock_two(sclk[1]), .shift_clock_three(sclk[2]), .shift_direction(dir),
    .sampling_mode(mode), .hold_bank_select(bank), .test_mode(test),
    .colour_video_inputs(video), .sampling_strobe(strobe), .column_outputs(cols),
    .sequencer_busy(busy));

  task automatic check(input logic [COLS-1:0] got, input logic [COLS-1:0] want);
    check_count++;
    if (got !== want) begin
      num_errors++;
      $display("FAIL at %0t: value differs from expected", $time);
    end
  endtask

  function automatic logic [COLS-1:0] exp_strobe(input int k);
    if (mode) return STROBE_TRIO << (3 * (dir ? k : TRIPLETS - 1 - k));
    return STROBE_ONE << (dir ? k : COLS - 1 - k);
  endfunction

  // Strobe order and bank contents expected from the pin traffic
  always @(negedge clk) begin
    seen = seen | {rout.drive, lout.drive};
    if (strobe !== STROBE_NONE) begin
      es = exp_strobe(nstb);
      check(strobe, es);
      check(COLS'(busy), COLS'(1'b1));
      for (int c = 0; c < COLS; c++) begin
        if (es[c] && bank) exp_one[c] = sample_t'(nstb * 3 + c % 3 + 1);
        if (es[c] && !bank) exp_two[c] = sample_t'(nstb * 3 + c % 3 + 1);
      end
      nstb++;
    end
  end

  task automatic check_cols();
    for (int c = 0; c < COLS; c++) begin
      check(COLS'(cols[c]), COLS'(bank ? exp_two[c] : exp_one[c]));
    end
  endtask

  task automatic run_line(input row_s r, input logic st);
    @(posedge clk);
    nstb = 0;
    seen = 2'b00;
    @(negedge clk);
    dir     = r.dir;
    mode    = r.mode;
    bank    = r.bank;
    stretch = st;
    repeat (8) @(negedge clk);
    check_cols();
    run = 1'b1;
    @(negedge clk);
    run = 1'b0;
    repeat (2) @(negedge clk);
    for (int w = 0; w < 6000 && !(done && !busy); w++) @(negedge clk);
    check(COLS'(nstb), COLS'(r.count));
    check(COLS'(busy), COLS'(1'b0));
    check(COLS'(seen), COLS'(r.casc));
    check(COLS'({rout.enable, lout.enable}), COLS'(r.casc));
    bank = ~r.bank;
    repeat (8) @(negedge clk);
    check_cols();
    $display("line done: dir %0b mode %0b stretch %0b", r.dir, r.mode, st);
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    final_report();
  end

  initial begin
    repeat (10) @(negedge clk);
    check(strobe, STROBE_NONE);
    check(COLS'({rout, lout}), COLS'(4'h4));
    check(COLS'(cols[0]), COLS'(8'h00));
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    $display("reset test done");
    foreach (rows[i]) begin
      run_line(rows[i], 1'b0);
    end
    run_line(rows[0], 1'b1);
    final_report();
  end
endmodule // tft_source_sampling_shifter_test

`default_nettype wire
